// [hdl/rtc_pkg.sv]
// Purpose: shared constants and types of the clock register map
// Assumes: 250 MHz system clock, 32.768 kHz time base sampled as a pin
// Notes:   byte-wide registers behind a two-wire serial slave
package rtc_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] SECONDS_OFS = 8'h00;
    localparam logic [7:0] MINUTES_OFS = 8'h01;
    localparam logic [7:0] LAST_TIME_OFS = 8'h06;
    localparam logic [7:0] LAST_NORMAL_OFS = 8'h09;
    localparam logic [7:0] UNLOCK_KEY_FIRST_OFS = 8'h20;
    localparam logic [7:0] UNLOCK_KEY_SECOND_OFS = 8'h21;
    localparam logic [7:0] SPECIAL_FUNCTION_CTRL_OFS = 8'h22;
    localparam int NUM_NORMAL = 10;
    localparam int NUM_TIME = 7;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int HALT_BIT = 7;
    localparam int OSC_FAIL_BIT = 7;
    localparam logic [3:0] UNITS_LAST = 4'h9;
    localparam logic [2:0] TENS_LAST = 3'h5;
    localparam logic [7:0] SECONDS_RESET = 8'h00;
    localparam logic [7:0] MINUTES_RESET = 8'h80;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] REFUSED_DATA = 8'h00;

    // ----------------------------------------------------------------
    // serial link and time base
    // ----------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h68;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int SYNC_STAGES = 3;
    localparam int OSC_HZ = 32768;
    localparam logic [14:0] OSC_LAST = 15'(OSC_HZ - 1);

    typedef enum {
        LINK_IDLE,
        LINK_ADDR,
        LINK_WDATA,
        LINK_ACK,
        LINK_LOAD,
        LINK_TX,
        LINK_MACK
    } link_state_e;
endpackage : rtc_pkg

// [hdl/rtc_bus_if.sv]
// Purpose: byte access path between serial slave and register file
// Assumes: single clock domain
// Notes:   ptr is the internal address pointer owned by the slave
interface rtc_bus_if;
    logic [7:0] ptr;
    logic wr_stb;
    logic [7:0] wr_data;
    logic rd_start;
    logic [7:0] rd_data;
    logic locked;

    modport slave (
        output ptr,
        output wr_stb,
        output wr_data,
        output rd_start,
        input rd_data,
        input locked
    );
    modport regs (
        input ptr,
        input wr_stb,
        input wr_data,
        input rd_start,
        output rd_data,
        output locked
    );
endinterface : rtc_bus_if

// [hdl/rtc_serial_slave.sv]
// Purpose: two-wire serial slave, address pointer and byte transfers
// Assumes: scl_lvl and sda_lvl are already synchronised and filtered
// Notes:   sda is driven low only; sda_oe high means pulling low
module rtc_serial_slave (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_lvl,
    input wire logic sda_lvl,
    output logic sda_out,
    output logic sda_oe,
    rtc_bus_if.slave bus
);
    rtc_pkg::link_state_e state_q;
    logic scl_p_q;
    logic sda_p_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic [7:0] wr_data_q;
    logic rw_q;
    logic first_q;
    logic ack_q;
    logic inc_q;
    logic wr_stb_q;
    logic rd_start_q;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic addr_hit;
    logic byte_done;

    assign scl_rise = scl_lvl & ~scl_p_q;
    assign scl_fall = ~scl_lvl & scl_p_q;
    assign start_cond = scl_lvl & scl_p_q & sda_p_q & ~sda_lvl;
    assign stop_cond = scl_lvl & scl_p_q & ~sda_p_q & sda_lvl;
    assign addr_hit = (sh_q[7:1] == rtc_pkg::SLAVE_ADDR);
    assign byte_done = (cnt_q == rtc_pkg::BITS_PER_BYTE);
    assign bus.ptr = ptr_q;
    assign bus.wr_stb = wr_stb_q;
    assign bus.wr_data = wr_data_q;
    assign bus.rd_start = rd_start_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            sda_out <= 1'b0;
        end else begin
            scl_p_q <= scl_lvl;
            sda_p_q <= sda_lvl;
            sda_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // transfer sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= rtc_pkg::LINK_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            wr_data_q <= 8'h00;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            ack_q <= 1'b0;
            inc_q <= 1'b0;
            wr_stb_q <= 1'b0;
            rd_start_q <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            wr_stb_q <= 1'b0;
            rd_start_q <= 1'b0;
            if (stop_cond) begin
                state_q <= rtc_pkg::LINK_IDLE;
                sda_oe <= 1'b0;
            end else if (start_cond) begin
                state_q <= rtc_pkg::LINK_ADDR;
                cnt_q <= 4'h0;
                first_q <= 1'b1;
                sda_oe <= 1'b0;
            end else begin
                case (state_q)
                    rtc_pkg::LINK_ADDR, rtc_pkg::LINK_WDATA: begin
                        if (scl_rise) begin
                            sh_q <= {sh_q[6:0], sda_lvl};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && byte_done) begin
                            cnt_q <= 4'h0;
                            state_q <= rtc_pkg::LINK_ACK;
                            inc_q <= 1'b0;
                            if (state_q == rtc_pkg::LINK_ADDR) begin
                                ack_q <= addr_hit;
                                sda_oe <= addr_hit;
                                rw_q <= sh_q[0];
                                rd_start_q <= addr_hit & sh_q[0];
                            end else if (first_q) begin
                                ptr_q <= sh_q;
                                first_q <= 1'b0;
                                ack_q <= 1'b1;
                                sda_oe <= 1'b1;
                            end else begin
                                // locked timekeeping bytes are not acknowledged
                                ack_q <= ~bus.locked;
                                sda_oe <= ~bus.locked;
                                wr_stb_q <= ~bus.locked;
                                wr_data_q <= sh_q;
                                inc_q <= 1'b1;
                            end
                        end
                    end
                    rtc_pkg::LINK_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            if (!ack_q) begin
                                state_q <= rtc_pkg::LINK_IDLE;
                            end else if (rw_q) begin
                                state_q <= rtc_pkg::LINK_LOAD;
                            end else begin
                                state_q <= rtc_pkg::LINK_WDATA;
                                if (inc_q) begin
                                    ptr_q <= ptr_q + 8'h01;
                                end
                            end
                        end
                    end
                    rtc_pkg::LINK_LOAD: begin
                        tx_q <= bus.rd_data;
                        sda_oe <= ~bus.rd_data[7];
                        cnt_q <= 4'h0;
                        state_q <= rtc_pkg::LINK_TX;
                    end
                    rtc_pkg::LINK_TX: begin
                        if (scl_rise) begin
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (byte_done) begin
                                sda_oe <= 1'b0;
                                state_q <= rtc_pkg::LINK_MACK;
                            end else begin
                                tx_q <= {tx_q[6:0], 1'b0};
                                sda_oe <= ~tx_q[6];
                            end
                        end
                    end
                    rtc_pkg::LINK_MACK: begin
                        if (scl_rise) begin
                            ack_q <= ~sda_lvl;
                        end else if (scl_fall) begin
                            ptr_q <= ptr_q + 8'h01;
                            state_q <= ack_q ? rtc_pkg::LINK_LOAD : rtc_pkg::LINK_IDLE;
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule : rtc_serial_slave

// [hdl/rtc_regmap.sv]
// Purpose: register map and seconds counter of a serial real-time clock
// Assumes: scl, sda, oscillator and supply-good arrive from outside clk
// Notes:   minutes take the seconds carry; higher fields are plain storage
//
// Overview of operation
// - registers 0x00 to 0x09 are decoded as the normal timekeeping set.
// - key one at 0x20, key two at 0x21, special control at 0x22.
// - after return to main supply, time registers refresh within one second.
// - reads starting before that refresh return time captured at backup entry.
// - seconds bit 7 halts the oscillator; 0 at power-up, kept at switchover.
// - seconds bits 6..4 hold BCD tens 0..5, kept at switchover.
// - out-of-range digits keep counting until rollover restores valid values.
// - seconds bits 3..0 hold BCD units 0..9, kept at switchover.
// - registers 0..9 refuse serial access while on backup supply.
// - reads start at the pointer: the last pointer write, plus one for each byte moved since.
module rtc_regmap (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic osc_in,
    input wire logic main_power_in,
    output logic sda_out,
    output logic sda_oe,
    output logic osc_enable
);
    localparam int NUM_IN = 4;

    rtc_bus_if bus ();

    logic [NUM_IN-1:0] raw_in;
    logic [NUM_IN-1:0] sync1_q;
    logic [NUM_IN-1:0] sync2_q;
    logic [NUM_IN-1:0] sync3_q;
    logic [NUM_IN-1:0] level_q;
    logic scl_lvl;
    logic sda_lvl;
    logic osc_lvl;
    logic power_ok;
    logic osc_p_q;
    logic power_p_q;
    logic [14:0] osc_cnt_q;
    logic sec_tick_q;
    logic stale_q;
    logic use_snap_q;
    localparam int NUM_NORMAL_T = rtc_pkg::NUM_NORMAL;
    localparam int NUM_TIME_T = rtc_pkg::NUM_TIME;
    logic [7:0] regs_q [NUM_NORMAL_T];
    logic [7:0] snap_q [NUM_TIME_T];
    logic [7:0] key_first_q;
    logic [7:0] key_second_q;
    logic [7:0] sf_ctrl_q;
    logic [8:0] sec_next;
    logic [8:0] min_next;
    logic [7:0] rd_mux;

    // one-step BCD increment; returns {carry, bit7, tens, units}
    function automatic logic [8:0] bcd_step(input logic [7:0] v);
        logic [3:0] units;
        logic [2:0] tens;
        logic carry;
        units = v[3:0];
        tens = v[6:4];
        carry = 1'b0;
        if (units == rtc_pkg::UNITS_LAST) begin
            units = 4'h0;
            if (tens == rtc_pkg::TENS_LAST) begin
                tens = 3'h0;
                carry = 1'b1;
            end else begin
                tens = tens + 3'h1;
            end
        end else begin
            // a written 0xA..0xF keeps counting and wraps to zero by itself
            units = units + 4'h1;
        end
        return {carry, v[7], tens, units};
    endfunction : bcd_step

    function automatic logic is_normal(input logic [7:0] a);
        return a <= rtc_pkg::LAST_NORMAL_OFS;
    endfunction : is_normal

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    assign raw_in = {main_power_in, osc_in, sda_in, scl_in};

    generate
        for (genvar i = 0; i < NUM_IN; i++) begin : g_sync
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    sync1_q[i] <= 1'b1;
                    sync2_q[i] <= 1'b1;
                    sync3_q[i] <= 1'b1;
                    level_q[i] <= 1'b1;
                end else begin
                    sync1_q[i] <= raw_in[i];
                    sync2_q[i] <= sync1_q[i];
                    sync3_q[i] <= sync2_q[i];
                    // a change counts only once two stages agree
                    if (sync2_q[i] == sync3_q[i]) begin
                        level_q[i] <= sync3_q[i];
                    end
                end
            end
        end
    endgenerate

    assign scl_lvl = level_q[0];
    assign sda_lvl = level_q[1];
    assign osc_lvl = level_q[2];
    assign power_ok = level_q[3];

    rtc_serial_slave u_slave (
        .clk(clk),
        .reset(reset),
        .scl_lvl(scl_lvl),
        .sda_lvl(sda_lvl),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .bus(bus.slave)
    );

    // ----------------------------------------------------------------
    // one-second time base
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            osc_p_q <= 1'b1;
            osc_cnt_q <= 15'h0000;
            sec_tick_q <= 1'b0;
        end else begin
            osc_p_q <= osc_lvl;
            sec_tick_q <= 1'b0;
            if (regs_q[0][rtc_pkg::HALT_BIT]) begin
                osc_cnt_q <= 15'h0000;
            end else if (osc_lvl && !osc_p_q) begin
                if (osc_cnt_q == rtc_pkg::OSC_LAST) begin
                    osc_cnt_q <= 15'h0000;
                    sec_tick_q <= 1'b1;
                end else begin
                    osc_cnt_q <= osc_cnt_q + 15'h0001;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            osc_enable <= 1'b1;
        end else begin
            osc_enable <= ~regs_q[0][rtc_pkg::HALT_BIT];
        end
    end

    // ----------------------------------------------------------------
    // backup supply tracking
    // ----------------------------------------------------------------
    // the visible copy may lag by up to one tick; a halted clock refreshes at once
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            power_p_q <= 1'b1;
            stale_q <= 1'b0;
            use_snap_q <= 1'b0;
        end else begin
            power_p_q <= power_ok;
            if (power_p_q && !power_ok) begin
                stale_q <= 1'b1;
            end else if (power_ok && (sec_tick_q || regs_q[0][rtc_pkg::HALT_BIT])) begin
                stale_q <= 1'b0;
            end
            if (bus.rd_start) begin
                use_snap_q <= stale_q;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_TIME_T; i++) begin
                snap_q[i] <= rtc_pkg::REG_RESET;
            end
        end else if (power_p_q && !power_ok) begin
            for (int i = 0; i < NUM_TIME_T; i++) begin
                snap_q[i] <= regs_q[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    assign sec_next = bcd_step(regs_q[0]);
    assign min_next = bcd_step(regs_q[1]);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_NORMAL_T; i++) begin
                regs_q[i] <= rtc_pkg::REG_RESET;
            end
            regs_q[0] <= rtc_pkg::SECONDS_RESET;
            regs_q[1] <= rtc_pkg::MINUTES_RESET;
            key_first_q <= rtc_pkg::REG_RESET;
            key_second_q <= rtc_pkg::REG_RESET;
            sf_ctrl_q <= rtc_pkg::REG_RESET;
        end else begin
            // seconds and a carried minutes step in the same cycle; a host write in that cycle wins
            if (sec_tick_q) begin
                regs_q[0] <= sec_next[7:0];
                if (sec_next[8]) begin
                    regs_q[1] <= min_next[7:0];
                end
            end
            if (bus.wr_stb) begin
                if (is_normal(bus.ptr) && power_ok) begin
                    regs_q[bus.ptr[3:0]] <= bus.wr_data;
                end
                case (bus.ptr)
                    rtc_pkg::UNLOCK_KEY_FIRST_OFS: key_first_q <= bus.wr_data;
                    rtc_pkg::UNLOCK_KEY_SECOND_OFS: key_second_q <= bus.wr_data;
                    rtc_pkg::SPECIAL_FUNCTION_CTRL_OFS: sf_ctrl_q <= bus.wr_data;
                    default: begin
                    end
                endcase
            end
        end
    end

    assign bus.locked = is_normal(bus.ptr) & ~power_ok;

    always_comb begin
        rd_mux = rtc_pkg::REFUSED_DATA;
        if (is_normal(bus.ptr)) begin
            if (!power_ok) begin
                rd_mux = rtc_pkg::REFUSED_DATA;
            end else if (use_snap_q && bus.ptr <= rtc_pkg::LAST_TIME_OFS) begin
                rd_mux = snap_q[bus.ptr[2:0]];
            end else begin
                rd_mux = regs_q[bus.ptr[3:0]];
            end
        end else begin
            case (bus.ptr)
                rtc_pkg::UNLOCK_KEY_FIRST_OFS: rd_mux = key_first_q;
                rtc_pkg::UNLOCK_KEY_SECOND_OFS: rd_mux = key_second_q;
                rtc_pkg::SPECIAL_FUNCTION_CTRL_OFS: rd_mux = sf_ctrl_q;
                default: rd_mux = rtc_pkg::REFUSED_DATA;
            endcase
        end
    end

    assign bus.rd_data = rd_mux;
endmodule : rtc_regmap

// [tb/rtc_regmap_monitor.sv]
// Purpose: port-level checks of the clock register map
// Assumes: sda wire is pulled up; scl period well above the sync latency
// Notes:   bound into every rtc_regmap instance
module rtc_regmap_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic osc_in,
    input wire logic main_power_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic osc_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // open drain: the data pin is only ever pulled low
    sda_low_only_a: assert property (@(posedge clk) sda_out == 1'b0)
        else $error("sda output driven high");
    // no reset guard here on purpose: this one checks the reset state itself
    reset_state_a: assert property (@(posedge clk) reset |=> osc_enable && !sda_oe)
        else $error("bad output state during reset");
    oe_scl_low_a: assert property (@(posedge clk) disable iff (reset)
        $changed(sda_oe) |-> !scl_in) else $error("sda drive changed while scl high");
    osc_scl_low_a: assert property (@(posedge clk) disable iff (reset)
        $changed(osc_enable) |-> !scl_in) else $error("halt changed outside a byte write");
    oe_bounded_a: assert property (@(posedge clk) disable iff (reset)
        $rose(sda_oe) |-> ##[1:500] !sda_oe) else $error("sda held low too long");
    stop_release_a: assert property (@(posedge clk) disable iff (reset)
        (scl_in && $rose(sda_in)) |-> !sda_oe [*8]) else $error("sda driven after stop");
    backup_halt_a: assert property (@(posedge clk) disable iff (reset)
        !main_power_in [*8] |-> $stable(osc_enable)) else $error("write taken on backup");
    start_release_a: assert property (@(posedge clk) disable iff (reset)
        (scl_in && $fell(sda_in)) |-> !sda_oe) else $error("start seen while driving");
    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    ack_seen_c: cover property (@(posedge clk) disable iff (reset) $rose(sda_oe));
    halt_seen_c: cover property (@(posedge clk) disable iff (reset) $fell(osc_enable));
    run_seen_c: cover property (@(posedge clk) disable iff (reset) $rose(osc_enable));
    backup_c: cover property (@(posedge clk) disable iff (reset) $fell(main_power_in));
endmodule : rtc_regmap_monitor

bind rtc_regmap rtc_regmap_monitor rtc_regmap_monitor_inst (
    .clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .osc_in(osc_in),
    .main_power_in(main_power_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .osc_enable(osc_enable));

// [tb/i2c_host_model.sv]
// Purpose: serial bus master driving scl and sda of the clock
// Assumes: 160 ns bit period, lines change at clk falling edges
// Notes:   each acknowledge bit or read byte is posted on res for one cycle
module i2c_host_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv,
    output logic res_valid,
    output logic [7:0] res
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        res_valid = 1'b0;
        res = 8'h00;
    end
    task quarter;
        repeat (10) @(negedge clk);
    endtask : quarter
    // also serves as repeated start: sda rises before scl
    task start;
        sda_drv = 1'b1;
        quarter;
        scl = 1'b1;
        quarter;
        sda_drv = 1'b0;
        quarter;
        scl = 1'b0;
        quarter;
    endtask : start
    task stop;
        sda_drv = 1'b0;
        quarter;
        scl = 1'b1;
        quarter;
        sda_drv = 1'b1;
        quarter;
    endtask : stop
    task bit_x(input logic b, output logic s);
        sda_drv = b;
        quarter;
        scl = 1'b1;
        quarter;
        s = sda_line;
        quarter;
        scl = 1'b0;
        quarter;
    endtask : bit_x
    task post(input logic [7:0] v);
        res = v;
        res_valid = 1'b1;
        @(negedge clk);
        res_valid = 1'b0;
    endtask : post
    task send(input logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(v[i], s);
        bit_x(1'b1, s);
        post({7'h00, s});
    endtask : send
    task recv(input logic last);
        logic [7:0] v;
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            v[i] = s;
        end
        bit_x(last, s);
        post(v);
    endtask : recv
endmodule : i2c_host_model

// [tb/rtc_regmap_tb.sv]
// Purpose: self-checking bench of the clock register map
// Assumes: no full second elapses in the run; time base still toggles
// Notes:   expected bus results queue up and are matched as they appear
module rtc_regmap_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic reset;
    logic osc_in;
    logic main_power_in;
    logic scl, sda_drv, sda_line, sda_out, sda_oe, osc_enable, res_valid;
    logic [7:0] res, v;
    logic [7:0] mem [0:35];
    logic [7:0] exp_q [$];
    int n_errors = 0;
    int compares = 0;
    int seed = 3;
    // pulled-up wire: low when either side pulls
    assign sda_line = sda_drv & ~sda_oe;
    always #2 clk = ~clk;
    always #80 osc_in = ~osc_in;
    rtc_regmap rtc_regmap_inst (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
        .osc_in(osc_in), .main_power_in(main_power_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .osc_enable(osc_enable));
    i2c_host_model i2c_host_model_inst (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv), .res_valid(res_valid), .res(res));
    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task check(input logic [7:0] seen, input logic [7:0] expct);
        compares++;
        if (seen !== expct) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expct);
        end
    endtask : check
    always @(posedge clk) begin
        if (res_valid === 1'b1) check(res, exp_q.pop_front());
    end
    task give_verdict;
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // transfers
    // ------------------------------------------------------------
    task do_write(input logic [7:0] ofs, input logic [7:0] val, input logic nack);
        i2c_host_model_inst.start;
        exp_q.push_back(8'h00);
        i2c_host_model_inst.send(8'hD0);
        exp_q.push_back(8'h00);
        i2c_host_model_inst.send(ofs);
        exp_q.push_back({7'h00, nack});
        i2c_host_model_inst.send(val);
        i2c_host_model_inst.stop;
    endtask : do_write
    // two bytes per read, so the pointer increment is always exercised
    task do_read(input logic [7:0] ofs, input logic [7:0] e0, input logic [7:0] e1);
        i2c_host_model_inst.start;
        exp_q.push_back(8'h00);
        i2c_host_model_inst.send(8'hD0);
        exp_q.push_back(8'h00);
        i2c_host_model_inst.send(ofs);
        i2c_host_model_inst.start;
        exp_q.push_back(8'h00);
        i2c_host_model_inst.send(8'hD1);
        exp_q.push_back(e0);
        i2c_host_model_inst.recv(1'b0);
        exp_q.push_back(e1);
        i2c_host_model_inst.recv(1'b1);
        i2c_host_model_inst.stop;
    endtask : do_read
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        osc_in = 1'b0;
        main_power_in = 1'b1;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        repeat (10) @(negedge clk);
        do_read(rtc_pkg::SECONDS_OFS, rtc_pkg::SECONDS_RESET, rtc_pkg::MINUTES_RESET);
        check({7'h00, osc_enable}, 8'h01);
        v = {1'b1, 3'(($random(seed) & 32'h7FFFFFFF) % 6), 4'(($random(seed) & 32'hFF) % 10)};
        do_write(rtc_pkg::SECONDS_OFS, v, 1'b0);
        repeat (5) @(negedge clk);
        check({7'h00, osc_enable}, 8'h00);
        do_read(rtc_pkg::SECONDS_OFS, v, rtc_pkg::MINUTES_RESET);
        // out-of-range digits are stored as written
        do_write(rtc_pkg::SECONDS_OFS, 8'hFF, 1'b0);
        for (int k = 0; k <= 35; k++) mem[k] = 8'h00;
        mem[0] = 8'hFF;
        for (int k = 1; k <= 34; k++) begin
            if (k <= 10 || k >= 32) begin
                v = 8'($random(seed));
                do_write(8'(k), v, 1'b0);
                mem[k] = (k == 10) ? 8'h00 : v;
            end
        end
        for (int k = 0; k <= 34; k++) begin
            if (k <= 10 || k >= 32) do_read(8'(k), mem[k], mem[k + 1]);
        end
        main_power_in = 1'b0;
        repeat (10) @(negedge clk);
        do_write(8'h07, 8'h5A, 1'b1);
        do_read(rtc_pkg::SECONDS_OFS, 8'h00, 8'h00);
        do_read(rtc_pkg::UNLOCK_KEY_FIRST_OFS, mem[32], mem[33]);
        main_power_in = 1'b1;
        repeat (20) @(negedge clk);
        do_read(rtc_pkg::SECONDS_OFS, 8'hFF, mem[1]);
        do_read(8'h07, mem[7], mem[8]);
        do_write(rtc_pkg::SECONDS_OFS, 8'h00, 1'b0);
        repeat (5) @(negedge clk);
        check({7'h00, osc_enable}, 8'h01);
        repeat (20) @(negedge clk);
        // halt again so that a second reset visibly restores the run state
        do_write(rtc_pkg::SECONDS_OFS, v | 8'h80, 1'b0);
        repeat (5) @(negedge clk);
        check({7'h00, osc_enable}, 8'h00);
        reset = 1'b1;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        check({7'h00, osc_enable}, 8'h01);
        repeat (10) @(negedge clk);
        do_read(rtc_pkg::SECONDS_OFS, rtc_pkg::SECONDS_RESET, rtc_pkg::MINUTES_RESET);
        repeat (20) @(negedge clk);
        give_verdict;
    end
    initial begin
        #400000;
        n_errors++;
        give_verdict;
    end
endmodule : rtc_regmap_tb
